// [hdl/dfd_pkg.sv]
package dfd_pkg;
   // ----------------------------------------
   // register map
   // ----------------------------------------
   localparam logic [3:0] ADDR_CONF   = 4'h0;
   localparam logic [3:0] ADDR_STATUS = 4'h1;
   localparam logic [3:0] ADDR_OTP    = 4'h2;
   // ----------------------------------------
   // configuration fields
   // ----------------------------------------
   localparam int CONF_W = 8;
   localparam int F_TSEL = 0;
   localparam int F_PWSEL = 2;
   localparam int F_IDXSTEP = 3;
   localparam int F_UARTSEL = 4;
   localparam logic [1:0] TSEL_143 = 2'h0;
   localparam logic [1:0] TSEL_150 = 2'h1;
   localparam logic [1:0] TSEL_157 = 2'h2;
   localparam logic [CONF_W-1:0] CONF_RST = 8'h00;
   // ----------------------------------------
   // status fields
   // ----------------------------------------
   localparam int S_TRIP = 0;
   localparam int S_OTPW = 1;
   localparam int S_S2G_A = 2;
   localparam int S_S2G_B = 3;
   localparam int S_S2V_A = 4;
   localparam int S_S2V_B = 5;
   localparam int S_OL_A = 6;
   localparam int S_OL_B = 7;
   localparam int S_UV = 8;
   localparam int S_DIS_A = 9;
   localparam int S_DIS_B = 10;
   localparam int STATUS_W = 11;
   // ----------------------------------------
   // temperature levels in degrees, short retry count and sync length
   // ----------------------------------------
   localparam logic [7:0] DEG_120 = 8'h78;
   localparam logic [7:0] DEG_143 = 8'h8F;
   localparam logic [7:0] DEG_150 = 8'h96;
   localparam logic [7:0] DEG_157 = 8'h9D;
   localparam logic [2:0] SHORT_RETRIES = 3'h3;
   localparam int SYNC_LEN = 3;
endpackage

// [hdl/dfd_sync.sv]
`timescale 1ns/1ps
module dfd_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } dfd_sync_s;
   dfd_sync_s st_q, st_d;
   always_comb begin
      st_d = st_q;
      st_d.s1 = d_in;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.q = st_q.s3;
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign q_out = st_q.q;
endmodule // dfd_sync

// [hdl/dfd_short.sv]
`timescale 1ns/1ps
module dfd_short (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // detector pulses and driver enable
   input wire logic s2g_in,
   input wire logic s2v_in,
   input wire logic drv_en_in,
   // flags
   output logic s2g_out,
   output logic s2v_out,
   output logic bridge_off_out
);
   typedef struct packed {
      logic [2:0] cnt;
      logic s2g;
      logic s2v;
      logic en_prev;
   } dfd_short_s;
   dfd_short_s st_q, st_d;
   logic latched;
   always_comb begin
      st_d = st_q;
      latched = st_q.s2g | st_q.s2v;
      st_d.en_prev = drv_en_in;
      if (latched) begin
         // restart only on disable then re-enable
         if (!st_q.en_prev && drv_en_in) begin
            st_d.s2g = 1'b0;
            st_d.s2v = 1'b0;
            st_d.cnt = 3'h0;
         end
      end else if (s2g_in || s2v_in) begin
         if (st_q.cnt == dfd_pkg::SHORT_RETRIES) begin
            st_d.s2g = s2g_in;
            st_d.s2v = s2v_in;
         end else begin
            st_d.cnt = st_q.cnt + 3'h1;
         end
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign s2g_out = st_q.s2g;
   assign s2v_out = st_q.s2v;
   assign bridge_off_out = st_q.s2g | st_q.s2v;
   a_short_latch: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      $rose(st_q.s2g | st_q.s2v) |-> $past(st_q.cnt) == 3'h3)
      else $error("short latched before retries");
   a_short_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      (st_q.s2g | st_q.s2v) && !drv_en_in |=> (st_q.s2g | st_q.s2v))
      else $error("short cleared without re-enable");
endmodule // dfd_short

// [hdl/dfd_fault_status_pin.sv]
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module dfd_fault_status_pin (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // register port
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   // analogue sensing, asynchronous
   input wire logic [7:0] temp_in,
   input wire logic s2g_a_in,
   input wire logic s2g_b_in,
   input wire logic s2v_a_in,
   input wire logic s2v_b_in,
   input wire logic cur_miss_a_in,
   input wire logic cur_miss_b_in,
   input wire logic undervolt_in,
   // motion and otp
   input wire logic drv_en_in,
   input wire logic step_in,
   input wire logic ms_zero_in,
   input wire logic [2:0] otp_conf_in,
   // outputs
   output logic bridge_a_on_out,
   output logic bridge_b_on_out,
   output logic fault_status_pin_out,
   output logic index_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] conf;
      logic conf_from_reg;
      logic otp_loaded;
      logic thermal_shutdown_flag;
      logic otpw;
      logic ol_a;
      logic ol_b;
      logic index;
      logic [15:0] rdata;
   } dfd_fault_status_pin_s;
   dfd_fault_status_pin_s st_q, st_d;
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   logic [7:0] temp_s;
   logic [6:0] pin_s;
   dfd_sync #(.W(8)) u_sync_temp (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .d_in(temp_in),
      .q_out(temp_s)
   );
   dfd_sync #(.W(7)) u_sync_pins (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .d_in({s2g_a_in, s2g_b_in, s2v_a_in, s2v_b_in, cur_miss_a_in,
             cur_miss_b_in, undervolt_in}),
      .q_out(pin_s)
   );
   // ----------------------------------------
   // short protection per bridge
   // ----------------------------------------
   logic short_to_ground_a, short_to_ground_b;
   logic supply_short_a, supply_short_b;
   logic off_a, off_b;
   dfd_short u_short_a (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .s2g_in(pin_s[6]),
      .s2v_in(pin_s[4]),
      .drv_en_in(drv_en_in),
      .s2g_out(short_to_ground_a),
      .s2v_out(supply_short_a),
      .bridge_off_out(off_a)
   );
   dfd_short u_short_b (
      .clk_in(clk_in),
      .arst_n_in(arst_n_in),
      .s2g_in(pin_s[5]),
      .s2v_in(pin_s[3]),
      .drv_en_in(drv_en_in),
      .s2g_out(short_to_ground_b),
      .s2v_out(supply_short_b),
      .bridge_off_out(off_b)
   );
   // ----------------------------------------
   // thresholds
   // ----------------------------------------
   logic [1:0] tsel;
   logic [7:0] t_off, t_warn;
   logic any_short;
   logic [dfd_pkg::STATUS_W-1:0] driver_status_word;
   always_comb begin
      tsel = st_q.conf[dfd_pkg::F_TSEL +: 2];
      t_off = dfd_pkg::DEG_143;
      t_warn = dfd_pkg::DEG_120;
      unique case (tsel)
         dfd_pkg::TSEL_150: begin
            t_off = dfd_pkg::DEG_150;
            t_warn = st_q.conf[dfd_pkg::F_PWSEL] ? dfd_pkg::DEG_143
                                                 : dfd_pkg::DEG_120;
         end
         dfd_pkg::TSEL_157: begin
            if (st_q.conf_from_reg) begin
               t_off = dfd_pkg::DEG_157;
               t_warn = dfd_pkg::DEG_143;
            end
         end
         default: begin
            t_off = dfd_pkg::DEG_143;
            t_warn = dfd_pkg::DEG_120;
         end
      endcase
   end
   assign any_short = short_to_ground_a | short_to_ground_b |
                      supply_short_a | supply_short_b;
   always_comb begin
      driver_status_word = '0;
      driver_status_word[dfd_pkg::S_TRIP] = st_q.thermal_shutdown_flag;
      driver_status_word[dfd_pkg::S_OTPW] = st_q.otpw;
      driver_status_word[dfd_pkg::S_S2G_A] = short_to_ground_a;
      driver_status_word[dfd_pkg::S_S2G_B] = short_to_ground_b;
      driver_status_word[dfd_pkg::S_S2V_A] = supply_short_a;
      driver_status_word[dfd_pkg::S_S2V_B] = supply_short_b;
      driver_status_word[dfd_pkg::S_OL_A] = st_q.ol_a;
      driver_status_word[dfd_pkg::S_OL_B] = st_q.ol_b;
      driver_status_word[dfd_pkg::S_UV] = pin_s[0];
      driver_status_word[dfd_pkg::S_DIS_A] = off_a;
      driver_status_word[dfd_pkg::S_DIS_B] = off_b;
   end
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rdata = 16'h0000;
      // otp values loaded once after reset release
      if (!st_q.otp_loaded) begin
         st_d.otp_loaded = 1'b1;
         st_d.conf[dfd_pkg::F_TSEL +: 2] =
            otp_conf_in[0] ? dfd_pkg::TSEL_150 : dfd_pkg::TSEL_143;
         st_d.conf[dfd_pkg::F_PWSEL] = otp_conf_in[1];
         st_d.conf[dfd_pkg::F_IDXSTEP] = otp_conf_in[2];
      end
      if (wr_in && addr_in == dfd_pkg::ADDR_CONF) begin
         st_d.conf = wdata_in[7:0];
         st_d.conf_from_reg = 1'b1;
      end
      // thermal trip holds until below pre-warning
      st_d.otpw = temp_s >= t_warn;
      if (temp_s >= t_off) begin
         st_d.thermal_shutdown_flag = 1'b1;
      end else if (temp_s < t_warn) begin
         st_d.thermal_shutdown_flag = 1'b0;
      end
      st_d.ol_a = pin_s[2];
      st_d.ol_b = pin_s[1];
      if (st_q.conf[dfd_pkg::F_IDXSTEP]) begin
         if (step_in) begin
            st_d.index = ~st_q.index;
         end
      end else begin
         st_d.index = ms_zero_in;
      end
      if (rd_in) begin
         unique case (addr_in)
            dfd_pkg::ADDR_CONF: st_d.rdata = {8'h00, st_q.conf};
            dfd_pkg::ADDR_STATUS: st_d.rdata =
               {5'h00, driver_status_word};
            dfd_pkg::ADDR_OTP: st_d.rdata = {13'h0000, otp_conf_in};
            default: st_d.rdata = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // open-load flags deliberately not used here
   assign bridge_a_on_out = drv_en_in & ~off_a &
                            ~st_q.thermal_shutdown_flag;
   assign bridge_b_on_out = drv_en_in & ~off_b &
                            ~st_q.thermal_shutdown_flag;
   assign fault_status_pin_out = st_q.thermal_shutdown_flag |
                                 any_short;
   assign index_out = st_q.index;
   assign rdata_out = st_q.rdata;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_thermal_hold: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      st_q.thermal_shutdown_flag && temp_s >= t_warn
      |=> st_q.thermal_shutdown_flag)
      else $error("thermal trip released too early");
   a_thermal_off: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      st_q.thermal_shutdown_flag
      |-> !bridge_a_on_out && !bridge_b_on_out)
      else $error("stage on during thermal trip");
   a_default_level: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      tsel == 2'h0 |-> t_off == 8'h8F && t_warn == 8'h78)
      else $error("default thresholds wrong");
   a_level_150: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      tsel == 2'h1 |-> t_off == 8'h96)
      else $error("150 level wrong");
   a_level_157: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      tsel == 2'h2 && st_q.conf_from_reg |-> t_off == 8'h9D
      && t_warn == 8'h8F)
      else $error("157 level wrong");
   a_bridge_sep: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      off_a && !off_b && !st_q.thermal_shutdown_flag && drv_en_in
      |-> !bridge_a_on_out && bridge_b_on_out)
      else $error("wrong bridge off");
   a_fault_pin: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      fault_status_pin_out == (st_q.thermal_shutdown_flag || any_short))
      else $error("fault pin mismatch");
   a_index_step: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      st_q.conf[3] && step_in && $stable(st_q.conf)
      |=> index_out != $past(index_out))
      else $error("index did not toggle");
   a_status_read: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      rd_in && addr_in == 4'h1
      |=> rdata_out[7:6] == $past({st_q.ol_b, st_q.ol_a}))
      else $error("status read wrong");
   // ----------------------------------------
   // checks: thermal levels and flags
   // ----------------------------------------
   a_level_150_hi: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      tsel == 2'h1 && st_q.conf[2] |-> t_warn == 8'h8F)
      else $error("150 level warning wrong");
   a_level_150_lo: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      tsel == 2'h1 && !st_q.conf[2] |-> t_warn == 8'h78)
      else $error("150 level warning wrong");
   a_thermal_set: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      temp_s >= t_off |=> st_q.thermal_shutdown_flag)
      else $error("thermal trip missed");
   a_thermal_clr: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      temp_s < t_warn |=> !st_q.thermal_shutdown_flag)
      else $error("thermal trip not released");
   a_pw_flag: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      temp_s >= t_warn |=> st_q.otpw)
      else $error("pre-warning missed");
   a_pw_clear: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      temp_s < t_warn |=> !st_q.otpw)
      else $error("pre-warning not released");
   // ----------------------------------------
   // checks: protection and reporting
   // ----------------------------------------
   a_short_a_off: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      short_to_ground_a || supply_short_a |-> !bridge_a_on_out)
      else $error("bridge a on during short");
   a_short_b_off: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      short_to_ground_b || supply_short_b |-> !bridge_b_on_out)
      else $error("bridge b on during short");
   a_open_load: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      1'b1 |=> st_q.ol_a == $past(pin_s[2])
      && st_q.ol_b == $past(pin_s[1]))
      else $error("open-load flag not following coil");
   a_ol_passive: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      drv_en_in && !off_a && !off_b && !st_q.thermal_shutdown_flag
      |-> bridge_a_on_out && bridge_b_on_out)
      else $error("bridge off without protective cause");
   a_fault_short: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      any_short || st_q.thermal_shutdown_flag |-> fault_status_pin_out)
      else $error("fault pin idle during fault");
   a_otp_load: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !st_q.otp_loaded && !wr_in
      |=> st_q.conf[1:0] == ($past(otp_conf_in[0]) ? 2'h1 : 2'h0)
      && st_q.conf[2] == $past(otp_conf_in[1])
      && st_q.conf[3] == $past(otp_conf_in[2]))
      else $error("otp defaults not loaded");
   a_index_zero: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !st_q.conf[3] |=> index_out == $past(ms_zero_in))
      else $error("index not showing counter zero");
   a_rdata_idle: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      !rd_in |=> rdata_out == 16'h0000)
      else $error("read data outside read cycle");
   a_rd_mapped: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      rd_in && addr_in > 4'h2 |=> rdata_out == 16'h0000)
      else $error("unmapped read not zero");
endmodule // dfd_fault_status_pin

// [verif/dfd_host.sv]
`timescale 1ns/1ps
module dfd_host (
   // clock
   input wire logic clk_in,
   // register port
   output logic [3:0] addr_out,
   output logic [15:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   // driver enable
   output logic drv_en_out
);
   // ----------------------------------------
   // expected read results
   // ----------------------------------------
   logic [15:0] exp_q[$];
   logic [15:0] mask_q[$];
   initial begin
      addr_out = 4'h0;
      wdata_out = 16'h0000;
      wr_out = 1'b0;
      rd_out = 1'b0;
      drv_en_out = 1'b1;
   end
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   task automatic write_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask
   task automatic read_reg(input logic [3:0] a, input logic [15:0] e,
                           input logic [15:0] m);
      exp_q.push_back(e);
      mask_q.push_back(m);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
   endtask
   // restart after a short: disable, then re-enable
   task automatic restart();
      @(posedge clk_in);
      drv_en_out <= 1'b0;
      repeat (3) @(posedge clk_in);
      drv_en_out <= 1'b1;
   endtask
endmodule // dfd_host

// [verif/dfd_fault_status_pin_tb.sv]
`timescale 1ns/1ps
module dfd_fault_status_pin_tb;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic [3:0] addr;
   logic [15:0] wdata;
   logic wr, rd, drv_en, bra, brb, fault, idx, i0;
   logic [15:0] rdata;
   logic [7:0] temp = 8'h19;
   logic [3:0] sh = 4'h0;
   logic [2:0] miss = 3'h0;
   logic [2:0] otp = 3'h0;
   logic [2:0] m;
   logic step = 1'b0;
   logic ms_zero = 1'b0;
   logic rd_d = 1'b0;
   logic [7:0] cf [4] = '{8'h00, 8'h01, 8'h05, 8'h02};
   logic [7:0] tr [4] = '{8'h8F, 8'h96, 8'h96, 8'h9D};
   logic [7:0] wn [4] = '{8'h78, 8'h78, 8'h8F, 8'h8F};
   integer seed = 73164;
   integer miscompares = 0;
   integer tests_run = 0;
   always #50 clk_in = ~clk_in;
   dfd_host host (.clk_in(clk_in), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd), .drv_en_out(drv_en));
   dfd_fault_status_pin dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .temp_in(temp), .s2g_a_in(sh[0]), .s2g_b_in(sh[1]),
      .s2v_a_in(sh[2]), .s2v_b_in(sh[3]), .cur_miss_a_in(miss[0]),
      .cur_miss_b_in(miss[1]), .undervolt_in(miss[2]), .drv_en_in(drv_en),
      .step_in(step), .ms_zero_in(ms_zero), .otp_conf_in(otp),
      .bridge_a_on_out(bra), .bridge_b_on_out(brb),
      .fault_status_pin_out(fault), .index_out(idx));
   // ----------------------------------------
   // compare and verdict
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ----------------------------------------
   // read monitor
   // ----------------------------------------
   always @(posedge clk_in) rd_d <= rd;
   always @(negedge clk_in) begin
      if (rd_d !== 1'b1) check(rdata, 16'h0000);
      else if (host.exp_q.size() == 0) check(16'h0001, 16'h0000);
      else check(rdata & host.mask_q.pop_front(),
                 host.exp_q.pop_front());
   end
   initial begin
      #3000000;
      miscompares++;
      print_verdict();
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic settle();
      repeat (8) @(posedge clk_in);
   endtask
   task automatic therm(input logic [7:0] t, input logic trip, input logic pw);
      @(posedge clk_in);
      temp <= t;
      settle();
      host.read_reg(dfd_pkg::ADDR_STATUS, {14'h0, pw, trip}, 16'h01FF);
      @(negedge clk_in);
      check({15'h0, fault}, {15'h0, trip});
      check({15'h0, bra}, {15'h0, ~trip});
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      host.read_reg(dfd_pkg::ADDR_CONF, 16'h0000, 16'hFFFF);
      host.read_reg(4'hF, 16'h0000, 16'hFFFF);
      for (int i = 0; i < 4; i++) begin
         host.write_reg(dfd_pkg::ADDR_CONF, {8'h00, cf[i]});
         therm(tr[i] - 8'h01, 1'b0, (tr[i] - 8'h01) >= wn[i]);
         therm(tr[i], 1'b1, 1'b1);
         therm(wn[i], 1'b1, 1'b1);
         therm(wn[i] - 8'h01, 1'b0, 1'b0);
      end
      @(posedge clk_in);
      temp <= 8'h19;
      settle();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         sh[i] <= 1'b1;
         repeat (3) @(posedge clk_in);
         if (i == 0) begin
            sh[i] <= 1'b0;
            settle();
            host.read_reg(dfd_pkg::ADDR_STATUS, 16'h0000, 16'hFFFF);
            @(negedge clk_in);
            check({15'h0, bra}, 16'h0001);
            @(posedge clk_in);
            sh[i] <= 1'b1;
            @(posedge clk_in);
         end
         @(posedge clk_in);
         sh[i] <= 1'b0;
         settle();
         host.read_reg(dfd_pkg::ADDR_STATUS,
            (16'h1 << (2 + i)) | (16'h1 << (9 + i % 2)), 16'hFFFF);
         @(negedge clk_in);
         check({14'h0, bra, brb}, (i % 2 == 1) ? 16'h2 : 16'h1);
         check({15'h0, fault}, 16'h0001);
         host.restart();
         settle();
         host.read_reg(dfd_pkg::ADDR_STATUS, 16'h0000, 16'hFFFF);
         @(negedge clk_in);
         check({14'h0, bra, brb, fault}, 16'h0006);
      end
      repeat (4) begin
         m = 3'($random(seed));
         @(posedge clk_in);
         miss <= m;
         repeat (8) begin
            @(posedge clk_in);
            step <= ~step;
         end
         settle();
         host.read_reg(dfd_pkg::ADDR_STATUS, {7'h0, m, 6'h0}, 16'hFFFF);
         @(negedge clk_in);
         check({14'h0, bra, brb, fault}, 16'h0006);
      end
      @(posedge clk_in);
      miss <= 3'h0;
      ms_zero <= 1'b1;
      @(negedge clk_in);
      @(negedge clk_in);
      check({15'h0, idx}, 16'h0001);
      host.write_reg(dfd_pkg::ADDR_CONF, 16'h0008);
      settle();
      @(negedge clk_in);
      i0 = idx;
      for (int k = 1; k < 4; k++) begin
         @(posedge clk_in);
         step <= 1'b1;
         @(posedge clk_in);
         step <= 1'b0;
         @(negedge clk_in);
         check({15'h0, idx}, {15'h0, i0 ^ k[0]});
      end
      @(posedge clk_in);
      otp <= 3'h3;
      arst_n_in <= 1'b0;
      repeat (10) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      host.read_reg(dfd_pkg::ADDR_CONF, 16'h0005, 16'hFFFF);
      host.read_reg(dfd_pkg::ADDR_OTP, 16'h0003, 16'hFFFF);
      settle();
      check(16'(host.exp_q.size()), 16'h0000);
      print_verdict();
   end
endmodule // dfd_fault_status_pin_tb
